//--- logic/pll_misc_clamp_start_config.sv
// Register bank and control logic for PLL lock edge, multi-function pin role,
// crystal clock output and clamp start position.
// Assumes an APB master on pclk; sync, pin, crystal and pixel inputs are synchronous to pclk.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pll_misc_clamp_start_config #(
  parameter logic [pll_clamp_pkg::SETTLE_W-1:0] SETTLE_LIMIT =
    pll_clamp_pkg::SETTLE_W'(pll_clamp_pkg::SETTLE_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pll_clamp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_line_sync_input,
  input wire logic second_line_sync_input,
  input wire logic sync_source_select,
  input wire logic multi_function_input_pin,
  input wire logic crystal_clock_in,
  input wire logic pixel_tick,
  input wire logic dc_restore_enable,
  input wire logic auto_black_level_comp_enable,
  input wire logic gain_offset_written,
  output logic pll_lock_pulse,
  output logic sample_clock_invert,
  output logic external_coast,
  output logic external_sample_clock,
  output logic crystal_clock_output,
  output logic dc_restore_pulse,
  output logic black_level_start_pulse,
  output logic offset_update_pulse,
  output logic [pll_clamp_pkg::START_W-1:0] clamp_start_pixel
);

  // Notes for users of this block:
  // - Register writes take effect at the accepting edge; there are no
  //   wait states, so a host may issue transfers back to back.
  // - Read data is captured in the setup cycle so that prdata comes from
  //   a flop; a write and a read of the same word in adjacent transfers
  //   still see the new value, as the read setup follows the write edge.
  // - Unmapped or misaligned words answer with an error and read as zero.
  // - The clamp start count is two independent registers; software that
  //   changes both halves may see one line clamp at a mixed position.
  // - Sync edges are found by comparing with last cycle's sample, so a
  //   level already high when reset ends reads as a rising edge once.
  // - The crystal divider samples the crystal on pclk, which limits the
  //   crystal rate to below half the pclk rate.
  // - The settle timer is a plain counter; its limit is a parameter so a
  //   bench can shorten it without touching the logic.

  // Whole state of the block in one record
  typedef struct packed {
    pll_clamp_pkg::pll_options_s options;
    logic [pll_clamp_pkg::START_HIGH_W-1:0] start_high;
    logic [7:0] start_low;
    logic [31:0] rdata;
    logic first_sync_prev;
    logic second_sync_prev;
    logic pin_prev;
    logic crystal_prev;
    logic crystal_half;
    pll_clamp_pkg::clamp_state_e clamp_state;
    logic [pll_clamp_pkg::START_W-1:0] pixel_count;
    logic pending;
    logic [pll_clamp_pkg::SETTLE_W-1:0] settle_count;
    logic lock_pulse;
    logic invert;
    logic coast;
    logic ext_clock;
    logic crystal_out;
    logic restore_pulse;
    logic black_pulse;
    logic update_pulse;
  } state_s;

  // Register index from a byte address
  function automatic logic [7:0] reg_index(input logic [pll_clamp_pkg::ADDR_W-1:0] addr);
    reg_index = addr[pll_clamp_pkg::IDX_LSB +: 8];
  endfunction

  // True when the address names one of the three registers
  function automatic logic is_mapped(input logic [pll_clamp_pkg::ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = reg_index(addr);
    is_mapped = (addr[pll_clamp_pkg::IDX_LSB-1:0] == 2'h0) &&
      ((idx == pll_clamp_pkg::IDX_PLL_LOCK_AND_PIN_OPTIONS) ||
       (idx == pll_clamp_pkg::IDX_CLAMP_START_PIXEL_HIGH) ||
       (idx == pll_clamp_pkg::IDX_CLAMP_START_PIXEL_LOW));
  endfunction

  state_s cur_ff;
  state_s nxt_ff;

  logic setup_phase;
  logic access_phase;
  logic write_hit;
  logic [7:0] acc_idx;
  logic active_sync;
  logic active_prev;
  logic lock_leading;
  logic pin_value;
  logic sync_trailing;
  logic internal_clamp;
  logic external_clamp;
  logic clamp_event;
  logic settle_expired;
  logic [pll_clamp_pkg::START_W-1:0] start_value;

  // Zero wait states; every access completes in its first access cycle
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_phase && !is_mapped(paddr);
  assign write_hit = access_phase && pwrite && is_mapped(paddr);
  assign acc_idx = reg_index(paddr);
  assign prdata = cur_ff.rdata;

  // Registered outputs
  assign pll_lock_pulse = cur_ff.lock_pulse;
  assign sample_clock_invert = cur_ff.invert;
  assign external_coast = cur_ff.coast;
  assign external_sample_clock = cur_ff.ext_clock;
  assign crystal_clock_output = cur_ff.crystal_out;
  assign dc_restore_pulse = cur_ff.restore_pulse;
  assign black_level_start_pulse = cur_ff.black_pulse;
  assign offset_update_pulse = cur_ff.update_pulse;
  assign clamp_start_pixel = start_value;

  // Start count spans the high and low registers
  assign start_value = {cur_ff.start_high, cur_ff.start_low};

  // Sync source in use and the edge the PLL locks on
  assign active_sync = sync_source_select ? second_line_sync_input : first_line_sync_input;
  assign active_prev = sync_source_select ? cur_ff.second_sync_prev : cur_ff.first_sync_prev;
  assign lock_leading = sync_source_select ? cur_ff.options.second_lock_leading
                                           : cur_ff.options.first_lock_leading;
  assign sync_trailing = active_prev && !active_sync;

  // Disabled pin reads as low whatever is on it
  assign pin_value = cur_ff.options.pin_disable ? 1'b0 : multi_function_input_pin;

  // Clamp from the pin only at its rising edge, else from the pixel counter
  assign external_clamp = (cur_ff.options.pin_role == pll_clamp_pkg::ROLE_EXT_CLAMP) &&
    pin_value && !cur_ff.pin_prev;
  assign internal_clamp = (cur_ff.options.pin_role != pll_clamp_pkg::ROLE_EXT_CLAMP) &&
    (cur_ff.clamp_state == pll_clamp_pkg::CLAMP_COUNT) && pixel_tick &&
    (cur_ff.pixel_count == start_value);
  assign clamp_event = external_clamp || internal_clamp;

  // Pending setting waited too long for a clamp; a clamp in the same
  // cycle takes precedence so only one update pulse is raised
  // Pending setting waited too long for a clamp
  assign settle_expired = cur_ff.pending && !clamp_event && (cur_ff.settle_count >= SETTLE_LIMIT);

  // Next state of the whole block
  always_comb begin
    nxt_ff = cur_ff;

    // Read data captured in the setup cycle so the access cycle shows a flop
    if (setup_phase) begin
      nxt_ff.rdata = 32'h0000_0000;
      case (acc_idx)
        pll_clamp_pkg::IDX_PLL_LOCK_AND_PIN_OPTIONS: nxt_ff.rdata[7:0] = cur_ff.options;
        pll_clamp_pkg::IDX_CLAMP_START_PIXEL_HIGH: nxt_ff.rdata[pll_clamp_pkg::START_HIGH_W-1:0] = cur_ff.start_high;
        pll_clamp_pkg::IDX_CLAMP_START_PIXEL_LOW: nxt_ff.rdata[7:0] = cur_ff.start_low;
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
      if (!is_mapped(paddr)) begin
        nxt_ff.rdata = 32'h0000_0000;
      end
    end

    // Register writes; reserved bit 2 is stored as written
    if (write_hit) begin
      case (acc_idx)
        pll_clamp_pkg::IDX_PLL_LOCK_AND_PIN_OPTIONS: nxt_ff.options = pwdata[7:0];
        pll_clamp_pkg::IDX_CLAMP_START_PIXEL_HIGH: nxt_ff.start_high = pwdata[pll_clamp_pkg::START_HIGH_W-1:0];
        pll_clamp_pkg::IDX_CLAMP_START_PIXEL_LOW: nxt_ff.start_low = pwdata[7:0];
        default: nxt_ff.start_low = cur_ff.start_low;
      endcase
    end

    // Edge history
    nxt_ff.first_sync_prev = first_line_sync_input;
    nxt_ff.second_sync_prev = second_line_sync_input;
    nxt_ff.pin_prev = pin_value;
    nxt_ff.crystal_prev = crystal_clock_in;

    // Lock on the rising edge when leading is chosen, else on the falling edge
    nxt_ff.lock_pulse = lock_leading ? (active_sync && !active_prev) : sync_trailing;

    // Pin role outputs; only the selected role ever sees the pin
    nxt_ff.invert = (cur_ff.options.pin_role == pll_clamp_pkg::ROLE_CLOCK_INVERT) && pin_value;
    nxt_ff.coast = (cur_ff.options.pin_role == pll_clamp_pkg::ROLE_EXT_COAST) && pin_value;
    nxt_ff.ext_clock = (cur_ff.options.pin_role == pll_clamp_pkg::ROLE_EXT_SAMPLE_CLOCK) && pin_value;

    // Crystal divider toggles on each rising crystal edge
    if (crystal_clock_in && !cur_ff.crystal_prev) begin
      nxt_ff.crystal_half = !cur_ff.crystal_half;
    end
    if (cur_ff.options.crystal_out_disable) begin
      nxt_ff.crystal_out = 1'b0;
    end else if (cur_ff.options.crystal_out_half) begin
      nxt_ff.crystal_out = cur_ff.crystal_half;
    end else begin
      nxt_ff.crystal_out = crystal_clock_in;
    end

    // Internal clamp counter restarts at every trailing sync edge
    case (cur_ff.clamp_state)
      pll_clamp_pkg::CLAMP_IDLE: begin
        if (sync_trailing) begin
          nxt_ff.clamp_state = pll_clamp_pkg::CLAMP_COUNT;
          nxt_ff.pixel_count = '0;
        end
      end
      pll_clamp_pkg::CLAMP_COUNT: begin
        if (sync_trailing) begin
          nxt_ff.pixel_count = '0;
        end else if (internal_clamp) begin
          nxt_ff.clamp_state = pll_clamp_pkg::CLAMP_IDLE;
        end else if (pixel_tick) begin
          nxt_ff.pixel_count = cur_ff.pixel_count + 1'b1;
        end
      end
      default: begin
        nxt_ff.clamp_state = pll_clamp_pkg::CLAMP_IDLE;
      end
    endcase

    // Clamp actions; offsets always follow the clamp
    nxt_ff.restore_pulse = clamp_event && dc_restore_enable;
    nxt_ff.black_pulse = clamp_event && auto_black_level_comp_enable;
    nxt_ff.update_pulse = clamp_event || settle_expired;

    // Pending setting; a new write in the clearing cycle keeps it pending
    if (gain_offset_written) begin
      nxt_ff.pending = 1'b1;
      nxt_ff.settle_count = '0;
    end else if (clamp_event || settle_expired) begin
      nxt_ff.pending = 1'b0;
      nxt_ff.settle_count = '0;
    end else if (cur_ff.pending) begin
      nxt_ff.settle_count = cur_ff.settle_count + 1'b1;
    end
  end

  // State register with reset defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.options <= pll_clamp_pkg::RST_PLL_LOCK_AND_PIN_OPTIONS;
      cur_ff.start_high <= pll_clamp_pkg::RST_CLAMP_START_PIXEL_HIGH;
      cur_ff.start_low <= pll_clamp_pkg::RST_CLAMP_START_PIXEL_LOW;
      cur_ff.clamp_state <= pll_clamp_pkg::CLAMP_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

endmodule // pll_misc_clamp_start_config

`default_nettype wire

//--- include/pll_clamp_pkg.sv
// Constants, field layouts and types for the PLL option and clamp start block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package pll_clamp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PLL_LOCK_AND_PIN_OPTIONS = 8'h13;
  localparam logic [7:0] IDX_CLAMP_START_PIXEL_HIGH = 8'h14;
  localparam logic [7:0] IDX_CLAMP_START_PIXEL_LOW = 8'h15;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // Reset values
  localparam logic [7:0] RST_PLL_LOCK_AND_PIN_OPTIONS = 8'h04;
  localparam logic [4:0] RST_CLAMP_START_PIXEL_HIGH = 5'h00;
  localparam logic [7:0] RST_CLAMP_START_PIXEL_LOW = 8'h03;

  // Field widths
  localparam int START_HIGH_W = 5;
  localparam int START_W = 13;

  // Multi-function pin roles
  typedef enum logic [1:0] {
    ROLE_CLOCK_INVERT = 2'b00,
    ROLE_EXT_CLAMP = 2'b01,
    ROLE_EXT_COAST = 2'b10,
    ROLE_EXT_SAMPLE_CLOCK = 2'b11
  } pin_role_e;

  // Layout of the lock and pin option register, msb first
  typedef struct packed {
    logic crystal_out_disable;
    logic crystal_out_half;
    pin_role_e pin_role;
    logic pin_disable;
    logic reserved_bit;
    logic second_lock_leading;
    logic first_lock_leading;
  } pll_options_s;

  // Internal clamp generator states
  typedef enum logic [0:0] {
    CLAMP_IDLE = 1'b0,
    CLAMP_COUNT = 1'b1
  } clamp_state_e;

  // Wait for a clamp before a pending setting is forced through
  localparam int SETTLE_MS = 100;
  localparam int CLOCK_MHZ = 200;
  localparam longint SETTLE_CYCLES = longint'(SETTLE_MS) * 1000 * CLOCK_MHZ;
  localparam int SETTLE_W = 25;

endpackage

//--- sim/video_sync_model.sv
// Line sync source: two syncs half a line apart and a pixel tick.
// Runs on pclk and stands still in reset.
`timescale 1ns/1ps
`default_nettype none
module video_sync_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic sync_a,
  output logic sync_b,
  output logic tick
);
  logic [5:0] pos_ff;
  // Forty-cycle line; edges on even places, ticks on odd, so they never meet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pos_ff <= 6'h00;
    else pos_ff <= (pos_ff == 6'h27) ? 6'h00 : pos_ff + 6'h01;
  end
  assign sync_a = pos_ff < 6'h06;
  assign sync_b = pos_ff >= 6'h14 && pos_ff < 6'h1A;
  assign tick = pos_ff[0];
endmodule // video_sync_model
`default_nettype wire

//--- sim/pll_clamp_asserts.sv
// Checker on the ports of the PLL option and clamp start block.
// Keeps a shadow of stored values taken from completed APB writes.
`timescale 1ns/1ps
`default_nettype none
module pll_clamp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pll_clamp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic first_line_sync_input,
  input wire logic second_line_sync_input,
  input wire logic sync_source_select,
  input wire logic multi_function_input_pin,
  input wire logic dc_restore_enable,
  input wire logic auto_black_level_comp_enable,
  input wire logic pll_lock_pulse,
  input wire logic sample_clock_invert,
  input wire logic external_coast,
  input wire logic external_sample_clock,
  input wire logic crystal_clock_output,
  input wire logic dc_restore_pulse,
  input wire logic black_level_start_pulse,
  input wire logic [pll_clamp_pkg::START_W-1:0] clamp_start_pixel
);
  logic [7:0] opt_ff;
  logic [12:0] start_ff;
  // Shadow moves at the accepting edge, as pready is always high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_ff <= 8'h04;
      start_ff <= 13'h0003;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h04C) opt_ff <= pwdata[7:0];
      if (paddr == 12'h050) start_ff[12:8] <= pwdata[4:0];
      if (paddr == 12'h054) start_ff[7:0] <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LOCK_FIRST: assert property (!sync_source_select && (opt_ff[0] ? $rose(first_line_sync_input)
    : $fell(first_line_sync_input)) |=> pll_lock_pulse) else $error("first sync lock missed");
  AST_LOCK_SECOND: assert property (sync_source_select && (opt_ff[1] ? $rose(second_line_sync_input)
    : $fell(second_line_sync_input)) |=> pll_lock_pulse) else $error("second sync lock missed");
  AST_PIN_OFF: assert property (opt_ff[3] |=>
    !sample_clock_invert && !external_coast && !external_sample_clock) else $error("disabled pin leaks");
  AST_PIN_ROLE: assert property (!opt_ff[3] |=> {external_sample_clock, external_coast, sample_clock_invert} ==
    ({3{$past(multi_function_input_pin)}} & {$past(opt_ff[5:4]) == 2'b11, $past(opt_ff[5:4]) == 2'b10,
    $past(opt_ff[5:4]) == 2'b00})) else $error("role output wrong");
  AST_EXT_CLAMP: assert property (!opt_ff[3] && opt_ff[5:4] == 2'b01 && $rose(multi_function_input_pin)
    && dc_restore_enable |=> dc_restore_pulse) else $error("external clamp missed");
  AST_CLAMP_PAIR: assert property (dc_restore_enable && auto_black_level_comp_enable
    && $stable(auto_black_level_comp_enable) && $stable(dc_restore_enable) |-> dc_restore_pulse == black_level_start_pulse)
    else $error("clamp pulses differ");
  AST_XTAL_OFF: assert property (opt_ff[7] |=> !crystal_clock_output) else $error("crystal out not low");
  AST_START_PIXEL: assert property (clamp_start_pixel == start_ff) else $error("start pixel wrong");
endmodule // pll_clamp_asserts
bind pll_misc_clamp_start_config pll_clamp_asserts u_pll_clamp_asserts (.*);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the PLL option and clamp start block.
// Acts as APB host and pin driver; the sync model supplies line timing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sync_source_select = 0, pixel_tick, err;
  logic multi_function_input_pin = 0, crystal_clock_in = 0, dc_restore_enable = 1, gain_offset_written = 0;
  logic auto_black_level_comp_enable = 0, first_line_sync_input, second_line_sync_input, pready, pslverr;
  logic pll_lock_pulse, sample_clock_invert, external_coast, external_sample_clock, crystal_clock_output;
  logic dc_restore_pulse, black_level_start_pulse, offset_update_pulse, s1_prev = 0, p;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [12:0] clamp_start_pixel;
  int mismatches = 0, n_checks = 0, cyc = 0, tks = 0, n, k;
  pll_misc_clamp_start_config #(.SETTLE_LIMIT(25'h0000032)) u_pll_misc_clamp_start_config (.*);
  video_sync_model u_video_sync_model (.pclk, .presetn, .sync_a(first_line_sync_input),
    .sync_b(second_line_sync_input), .tick(pixel_tick));
  always #2.5 pclk = !pclk;
  // Crystal input, ticks since the first sync's trailing edge, cycle ceiling
  always @(posedge pclk) begin
    cyc++;
    if (cyc % 4 == 0) crystal_clock_in <= !crystal_clock_in;
    s1_prev <= first_line_sync_input;
    tks <= (s1_prev && !first_line_sync_input) ? 0 : tks + int'(pixel_tick);
    if (cyc == 4000) mismatches++;
    if (cyc == 4000) wrap_up();
  end
  // Request held until the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Edges counted into n until the strobe is seen, bounded
  task automatic await(ref logic s);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s !== 1'b1 && n < 100);
  endtask
  task automatic pulse_write();
    gain_offset_written <= 1'b1;
    @(posedge pclk);
    gain_offset_written <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, field width of the high half, unmapped word
    apb(1'b0, 12'h04C, 32'h00000000);
    `CHK("options", 32'h00000004, rd)
    apb(1'b1, 12'h050, 32'hFFFFFFFF);
    apb(1'b0, 12'h054, 32'h00000000);
    `CHK("start_low", 32'h00000003, rd)
    `CHK("start_out", 13'h1F03, clamp_start_pixel)
    apb(1'b0, 12'h058, 32'h00000000);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, 12'h050, 32'h00000000);
    apb(1'b1, 12'h054, 32'h00000005);
    // Lock edge per input; the pulse finds the sync at its new level
    for (k = 0; k < 4; k++) begin
      sync_source_select <= k[1];
      apb(1'b1, 12'h04C, 32'(k[0]) << k[1]);
      repeat (4) @(posedge pclk);
      await(pll_lock_pulse);
      p = k[1] ? second_line_sync_input : first_line_sync_input;
      `CHK("lock_edge", {1'b1, k[0]}, {pll_lock_pulse, p})
    end
    // Every role, pin enabled then disabled; table holds the one-hot per role, zero for external clamp
    for (k = 0; k < 8; k++) begin
      apb(1'b1, 12'h04C, 32'(k * 16 % 64 + k / 4 * 8));
      multi_function_input_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("role", k > 3 ? 3'b000 : 3'((12'h881 >> (3 * k)) & 12'h007), {external_sample_clock, external_coast, sample_clock_invert})
      multi_function_input_pin <= 1'b0;
    end
    // Internal clamp lands on tick start+1; black comp gated; pending offset moves
    sync_source_select <= 1'b0;
    apb(1'b1, 12'h04C, 32'h00000000);
    repeat (80) @(posedge pclk);
    await(dc_restore_pulse);
    `CHK("clamp_tick", 6, tks)
    `CHK("auto_black_level_comp_off", 1'b0, black_level_start_pulse)
    auto_black_level_comp_enable <= 1'b1;
    pulse_write();
    await(dc_restore_pulse);
    `CHK("clamp_all", 2'b11, {black_level_start_pulse, offset_update_pulse})
    // External clamp: internal clamps stop; pin edge clamps; timeout forces update
    apb(1'b1, 12'h04C, 32'h00000010);
    await(dc_restore_pulse);
    `CHK("no_internal", 100, n)
    pulse_write();
    multi_function_input_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("ext_clamp", 2'b11, {dc_restore_pulse, offset_update_pulse})
    multi_function_input_pin <= 1'b0;
    pulse_write();
    await(offset_update_pulse);
    `CHK("settle", 1'b1, n > 44 && n < 54)
    // Crystal output halved, then held low; input rises 8 times per window
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 12'h04C, 32'h00000040 << k);
      repeat (4) @(posedge pclk);
      n = 0;
      repeat (64) begin
        p = crystal_clock_output;
        @(posedge pclk);
        n += int'(crystal_clock_output && !p);
      end
      `CHK("xtal_rises", 1'b1, k ? n == 0 : n > 2 && n < 6)
    end
    wrap_up();
  end
  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
